// *** dv/dsp_core_interrupt_logic_bench.sv ***
// Purpose: self-checking bench of the interrupt controller
// Assumes: one wait cycle per bus access, takes a cycle after the boundary
// Notes: results are captured by a monitor and compared two edges later
`timescale 1ns/1ps
`default_nettype none
module dsp_core_interrupt_logic_bench;
   import dsp_int_pkg::*;
   logic clk = 1'b0;
   logic resetn = 1'b0;
   logic [ADDR_W-1:0] avs_address = '0;
   logic avs_read = 1'b0;
   logic avs_write = 1'b0;
   logic [31:0] avs_writedata = '0;
   logic [31:0] avs_readdata, q;
   logic avs_waitrequest, timer_irq, serial_irq, interprocessor_source, external_irq_pin;
   logic debug_trap = 1'b0, instr_boundary = 1'b0, enable_ints_instr = 1'b0;
   logic disable_ints_instr = 1'b0, ireturn_instr = 1'b0, soft_int_instr = 1'b0;
   logic [PC_W-1:0] core_pc = '0;
   logic [SOFT_W-1:0] soft_int_index = '0;
   logic vector_take, trap_take, return_take, return_to_cache, global_int_enable, last_cache;
   logic [PC_W-1:0] vector_addr, return_pc, last_vec, last_ret, vb, pc0;
   logic [PRIO_W-1:0] current_priority_level;
   logic [3:0] fire = 4'h0;
   logic slow = 1'b0;
   int error_cnt = 0, compares = 0, takes = 0, m_pend, n;
   always #2 clk = ~clk;
   dsp_int_ctrl i_dut (.clk, .resetn, .avs_address, .avs_read, .avs_write, .avs_writedata,
      .avs_readdata, .avs_waitrequest, .timer_irq, .serial_irq, .interprocessor_source,
      .external_irq_pin, .debug_trap, .instr_boundary, .core_pc, .enable_ints_instr,
      .disable_ints_instr, .ireturn_instr, .soft_int_instr, .soft_int_index, .vector_take,
      .trap_take, .vector_addr, .return_take, .return_to_cache, .return_pc,
      .global_int_enable, .current_priority_level);
   irq_src_model i_src (.clk, .resetn, .fire, .slow, .timer_irq, .serial_irq,
      .interprocessor_source, .external_irq_pin);
   always @(posedge clk) begin
      if (vector_take === 1'b1) begin
         takes <= takes + 1;
         last_vec <= vector_addr;
      end
      if (return_take === 1'b1) begin
         last_ret <= return_pc;
         last_cache <= return_to_cache;
      end
   end
   task automatic chk(input string nm, input logic [31:0] got, input logic [31:0] exp);
      compares++;
      if (got !== exp) begin
         error_cnt++;
         $display("ERROR %s expected %h seen %h", nm, exp, got);
      end
   endtask
   task automatic bus(input logic wr, input logic [ADDR_W-1:0] a, input logic [31:0] d);
      int k;
      k = 0;
      avs_address <= a;
      avs_write <= wr;
      avs_read <= !wr;
      avs_writedata <= d;
      do begin
         @(posedge clk);
         k++;
      end while (avs_waitrequest !== 1'b0 && k < 50);
      chk("bus answer", 32'(k < 50), 32'h1);
      q = avs_readdata;
      avs_read <= 1'b0;
      avs_write <= 1'b0;
      @(posedge clk);
   endtask
   // one-cycle core strobes, three extra edges so the monitor has landed
   task automatic step(input logic [5:0] s);
      {debug_trap, soft_int_instr, instr_boundary, ireturn_instr, disable_ints_instr,
         enable_ints_instr} <= s;
      @(posedge clk);
      {debug_trap, soft_int_instr, instr_boundary, ireturn_instr, disable_ints_instr,
         enable_ints_instr} <= 6'h00;
      repeat (3) @(posedge clk);
   endtask
   task automatic src(input logic [3:0] f, input logic s);
      fire <= f;
      slow <= s;
      @(posedge clk);
      fire <= 4'h0;
      repeat (10) @(posedge clk);
   endtask
   task automatic end_of_test;
      $display("compares %0d error_cnt %0d", compares, error_cnt);
      if (error_cnt == 0 && compares > 0) $display("ALL TESTS PASSED");
      else $display("TESTS FAILED");
      $finish;
   endtask
   initial begin
      repeat (5000) @(posedge clk);
      error_cnt++;
      end_of_test;
   end
   initial begin
      void'($urandom(85221));
      repeat (5) @(posedge clk);
      resetn <= 1'b1;
      @(posedge clk);
      for (int a = 0; a < 8; a++) begin
         bus(1'b0, ADDR_W'(a * 4), 32'h0);
         chk("reset value", q, 32'h0);
      end
      vb = PC_W'($urandom);
      pc0 = PC_W'($urandom);
      bus(1'b1, REG_VBASE, 32'(vb));
      bus(1'b1, REG_PRIO_LO, 32'h5);
      bus(1'b1, REG_PRIO_HI, 32'h5);
      src(4'hF, 1'b0);
      m_pend = 'hF;
      bus(1'b0, REG_PENDING, 32'h0);
      chk("pending", q, 32'(m_pend));
      bus(1'b1, REG_PENDING, 32'h0);
      bus(1'b0, REG_PENDING, 32'h0);
      chk("pending", q, 32'(m_pend));
      bus(1'b1, REG_PENDING, 32'h5);
      m_pend = m_pend & ~'h5;
      bus(1'b0, REG_PENDING, 32'h0);
      chk("pending", q, 32'(m_pend));
      step(6'h01);
      core_pc <= pc0;
      step(6'h08);
      chk("vector", 32'(last_vec), 32'(PC_W'(vb + SRC_VEC[SRC_EXT])));
      m_pend = 'h8;
      src(4'h2, 1'b1);
      bus(1'b0, REG_PENDING, 32'h0);
      chk("pending", q, 32'(m_pend));
      bus(1'b0, REG_PSW, 32'h0);
      chk("status", q, 32'h1);
      chk("level", 32'(current_priority_level), 32'h1);
      bus(1'b1, REG_CSTATE, 32'h1);
      step(6'h04);
      chk("return pc", 32'(last_ret), 32'(pc0));
      chk("cache resume", 32'(last_cache), 32'h1);
      chk("enable", 32'(global_int_enable), 32'h1);
      bus(1'b1, REG_CSTATE, 32'h0);
      step(6'h08);
      chk("vector", 32'(last_vec), 32'(PC_W'(vb + SRC_VEC[SRC_IPC])));
      step(6'h04);
      // timer at level 0 must stay pending while the pin is taken
      bus(1'b1, REG_PRIO_LO, 32'h4);
      n = takes;
      instr_boundary <= 1'b1;
      src(4'h3, 1'b0);
      instr_boundary <= 1'b0;
      chk("takes", 32'(takes), 32'(n + 1));
      chk("vector", 32'(last_vec), 32'(PC_W'(vb + SRC_VEC[SRC_EXT])));
      bus(1'b0, REG_PENDING, 32'h0);
      chk("pending", q, 32'h1);
      step(6'h04);
      for (int i = 0; i < 3; i++) begin
         n = (i == 0) ? 0 : (i == 1) ? 63 : $urandom_range(62, 1);
         soft_int_index <= SOFT_W'(n);
         core_pc <= pc0 + PC_W'(i);
         step(6'h02);
         step(6'h18);
         chk("soft vector", 32'(last_vec), 32'(PC_W'(vb + VEC_SOFT_BASE + PC_W'(4 * n))));
         step(6'h04);
         chk("return pc", 32'(last_ret), 32'(PC_W'(pc0 + PC_W'(i))));
      end
      bus(1'b1, REG_PRIO_LO, 32'h1);
      step(6'h28);
      chk("trap vector", 32'(last_vec), 32'(PC_W'(vb + VEC_TRAP)));
      end_of_test;
   end
endmodule // dsp_core_interrupt_logic_bench
`default_nettype wire

// *** dv/dsp_int_ctrl_asserts.sv ***
// Purpose: port checks of the interrupt controller
// Assumes: bench keeps other takes away from pin tests
// Notes: vector base is not seen here, addresses are checked in the bench
`timescale 1ns/1ps
`default_nettype none
module dsp_int_ctrl_asserts
   import dsp_int_pkg::*;
(
   // clock and reset
   input wire logic clk,
   input wire logic resetn,
   // core side
   input wire logic external_irq_pin,
   input wire logic debug_trap,
   input wire logic instr_boundary,
   input wire logic enable_ints_instr,
   input wire logic disable_ints_instr,
   input wire logic ireturn_instr,
   input wire logic soft_int_instr,
   // results
   input wire logic vector_take,
   input wire logic trap_take,
   input wire logic return_take,
   input wire logic global_int_enable,
   input wire logic [PRIO_W-1:0] current_priority_level
);
   default clocking @(posedge clk); endclocking
   default disable iff (!resetn);
   property p_entry_off;
      vector_take && !trap_take |-> !global_int_enable;
   endproperty
   a_entry_off: assert property (p_entry_off) else $error("enable set at entry");
   property p_ret_on;
      ireturn_instr |=> return_take && global_int_enable;
   endproperty
   a_ret_on: assert property (p_ret_on) else $error("return did not re-enable");
   property p_di;
      disable_ints_instr && !enable_ints_instr && !ireturn_instr |=> !global_int_enable;
   endproperty
   a_di: assert property (p_di) else $error("disable ignored");
   property p_ei;
      enable_ints_instr && !disable_ints_instr && !ireturn_instr && !instr_boundary
         && !soft_int_instr |=> global_int_enable;
   endproperty
   a_ei: assert property (p_ei) else $error("enable ignored");
   property p_soft;
      soft_int_instr && instr_boundary && !debug_trap |=> vector_take && !trap_take;
   endproperty
   a_soft: assert property (p_soft) else $error("soft interrupt not taken");
   property p_trap;
      debug_trap && instr_boundary |=> trap_take && vector_take;
   endproperty
   a_trap: assert property (p_trap) else $error("trap not taken");
   // guard against a take that skips the pin synchroniser
   property p_pin_lat;
      $rose(external_irq_pin) |-> !vector_take [*4];
   endproperty
   a_pin_lat: assert property (p_pin_lat) else $error("pin serviced too early");
   property p_reset_idle;
      $rose(resetn) |-> !global_int_enable && current_priority_level == RST_LEVEL;
   endproperty
   a_reset_idle: assert property (p_reset_idle) else $error("not idle after reset");
   property p_boundary;
      vector_take |-> $past(instr_boundary);
   endproperty
   a_boundary: assert property (p_boundary) else $error("take off a boundary");
endmodule // dsp_int_ctrl_asserts
bind dsp_int_ctrl dsp_int_ctrl_asserts i_chk (.clk, .resetn, .external_irq_pin, .debug_trap,
   .instr_boundary, .enable_ints_instr, .disable_ints_instr, .ireturn_instr, .soft_int_instr,
   .vector_take, .trap_take, .return_take, .global_int_enable, .current_priority_level);
`default_nettype wire

// *** dv/irq_src_model.sv ***
// Purpose: far side of the block, the timer, serial and interprocessor sources and the pin driver
// Assumes: fire bits follow the pending bit order
// Notes: slow stretches the pin pulse by one cycle
`timescale 1ns/1ps
`default_nettype none
module irq_src_model (
   // clock and reset
   input wire logic clk,
   input wire logic resetn,
   // bench commands
   input wire logic [3:0] fire,
   input wire logic slow,
   // requests
   output logic timer_irq = 1'b0,
   output logic serial_irq = 1'b0,
   output logic interprocessor_source = 1'b0,
   output logic external_irq_pin = 1'b0
);
   logic [1:0] hold_q;
   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         timer_irq <= 1'b0;
         serial_irq <= 1'b0;
         interprocessor_source <= 1'b0;
         external_irq_pin <= 1'b0;
         hold_q <= 2'h0;
      end else begin
         timer_irq <= fire[0];
         serial_irq <= fire[2];
         interprocessor_source <= fire[3];
         // pin held at least two cycles, pulse sources one cycle
         if (fire[1]) hold_q <= slow ? 2'h3 : 2'h2;
         else if (hold_q != 2'h0) hold_q <= hold_q - 2'h1;
         external_irq_pin <= fire[1] | (hold_q > 2'h1);
      end
   end
endmodule // irq_src_model
`default_nettype wire

// *** rtl/arb_if.sv ***
// Purpose: pending and priority view handed to the arbiter, and its verdict
// Assumes: one two-bit priority field per source, lowest source in the low bits
// Notes: requester drives the view, the arbiter answers combinationally
`timescale 1ns/1ps
`default_nettype none
interface arb_if;
   import dsp_int_pkg::*;
   logic [NUM_SRC-1:0] pending;
   logic [NUM_SRC*PRIO_W-1:0] prio;
   logic [PRIO_W-1:0] floor;
   logic valid;
   logic [1:0] idx;
   logic [PRIO_W-1:0] level;
   modport requester (output pending, prio, floor, input valid, idx, level);
   modport arbiter (input pending, prio, floor, output valid, idx, level);
endinterface
`default_nettype wire

// *** rtl/dsp_int_ctrl.sv ***
// Purpose: hardware and software interrupt handling of the signal-processor core
// Assumes: core strobes are one-cycle pulses synchronous to clk
// Notes: registers reached over Avalon-MM, two cycles per access
//
// Register access over Avalon-MM and the register offsets are this design's own decisions.
`timescale 1ns/1ps
`default_nettype none
module dsp_int_ctrl
   import dsp_int_pkg::*;
(
   // clock and reset
   input wire logic clk,
   input wire logic resetn,
   // register bus
   input wire logic [ADDR_W-1:0] avs_address,
   input wire logic avs_read,
   input wire logic avs_write,
   input wire logic [31:0] avs_writedata,
   output logic [31:0] avs_readdata,
   output logic avs_waitrequest,
   // interrupt sources
   input wire logic timer_irq,
   input wire logic serial_irq,
   input wire logic interprocessor_source,
   input wire logic external_irq_pin,
   input wire logic debug_trap,
   // core sequencer
   input wire logic instr_boundary,
   input wire logic [PC_W-1:0] core_pc,
   input wire logic enable_ints_instr,
   input wire logic disable_ints_instr,
   input wire logic ireturn_instr,
   input wire logic soft_int_instr,
   input wire logic [SOFT_W-1:0] soft_int_index,
   // vectoring
   output logic vector_take,
   output logic trap_take,
   output logic [PC_W-1:0] vector_addr,
   output logic return_take,
   output logic return_to_cache,
   output logic [PC_W-1:0] return_pc,
   // status
   output logic global_int_enable,
   output logic [PRIO_W-1:0] current_priority_level
);
   arb_if arb ();

   logic ext_rise;
   logic [NUM_SRC-1:0] src_evt;
   logic [NUM_SRC-1:0] pending_q;
   logic [3:0] priority_control_lo_q;
   logic [3:0] priority_control_hi_q;
   logic [PC_W-1:0] vbase_q;
   logic ien_q;
   logic [PRIO_W-1:0] current_priority_level_q;
   logic [PRIO_W-1:0] previous_priority_level_q;
   logic [PC_W-1:0] interrupt_return_pc_q;
   logic [CSTATE_W-1:0] cstate_q;
   logic handler_q;
   logic [1:0] active_src_q;
   logic ack_q;
   logic [31:0] rdata_q;
   logic take_trap;
   logic take_soft;
   logic take_hw;
   logic wr_en;
   logic [31:0] processor_status_word;
   logic [NUM_SRC-1:0] svc_clr;
   logic vector_take_q;
   logic trap_take_q;
   logic [PC_W-1:0] vector_addr_q;
   logic return_take_q;
   logic return_to_cache_q;
   logic [PC_W-1:0] return_pc_q;

   ext_pin_sync u_pin (
      .clk(clk),
      .resetn(resetn),
      .external_irq_pin(external_irq_pin),
      .rise(ext_rise)
   );

   irq_arbiter u_arb (
      .a(arb)
   );

   assign src_evt[SRC_TIMER] = timer_irq;
   assign src_evt[SRC_EXT] = ext_rise;
   assign src_evt[SRC_SERIAL] = serial_irq;
   assign src_evt[SRC_IPC] = interprocessor_source;

   assign arb.pending = pending_q;
   assign arb.prio = {priority_control_hi_q, priority_control_lo_q};
   assign arb.floor = current_priority_level_q;

   // trap and hardware service happen only at a boundary, soft whenever strobed; trap outranks all
   assign take_trap = instr_boundary & debug_trap;
   assign take_soft = soft_int_instr & ~take_trap;
   assign take_hw = instr_boundary & ~debug_trap & ~soft_int_instr & ien_q & arb.valid;

   // bus slave: waitrequest for one cycle, then the access completes
   assign avs_waitrequest = (avs_read | avs_write) & ~ack_q;
   assign wr_en = avs_write & ack_q;

   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) ack_q <= 1'b0;
      else ack_q <= (avs_read | avs_write) & ~ack_q;
   end

   assign processor_status_word = {17'h00000, ien_q, 10'h000, previous_priority_level_q, current_priority_level_q};

   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         rdata_q <= 32'h00000000;
      end else if (avs_read && !ack_q) begin
         case (avs_address)
            REG_PENDING: rdata_q <= {28'h0000000, pending_q};
            REG_PRIO_LO: rdata_q <= {28'h0000000, priority_control_lo_q};
            REG_PRIO_HI: rdata_q <= {28'h0000000, priority_control_hi_q};
            REG_VBASE: rdata_q <= {12'h000, vbase_q};
            REG_PSW: rdata_q <= processor_status_word;
            REG_RET_PC: rdata_q <= {12'h000, interrupt_return_pc_q};
            REG_CSTATE: rdata_q <= {16'h0000, cstate_q};
            default: rdata_q <= 32'h00000000;
         endcase
      end
   end
   assign avs_readdata = rdata_q;

   // pending bits, one per source
   assign svc_clr = take_hw ? (4'h1 << arb.idx) : 4'h0;
   generate
      for (genvar g = 0; g < NUM_SRC; g++) begin : g_pend
         logic blocked;
         // repeat from the source being handled is dropped until ei, return or a PSW write that sets the enable bit
         assign blocked = handler_q & ~ien_q & (active_src_q == 2'(g));
         always_ff @(posedge clk or negedge resetn) begin
            if (!resetn) begin
               pending_q[g] <= RST_PENDING[g];
            end else if (src_evt[g] && !blocked) begin
               pending_q[g] <= 1'b1;
            end else if (svc_clr[g]) begin
               pending_q[g] <= 1'b0;
            end else if (wr_en && avs_address == REG_PENDING && avs_writedata[g]) begin
               pending_q[g] <= 1'b0;
            end
         end
      end
   endgenerate

   // priority fields: software must disable globally before changing them
   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         priority_control_lo_q <= RST_PRIO_HALF;
         priority_control_hi_q <= RST_PRIO_HALF;
      end else if (wr_en) begin
         if (avs_address == REG_PRIO_LO) priority_control_lo_q <= avs_writedata[3:0];
         if (avs_address == REG_PRIO_HI) priority_control_hi_q <= avs_writedata[3:0];
      end
   end

   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) vbase_q <= RST_PC;
      else if (wr_en && avs_address == REG_VBASE) vbase_q <= avs_writedata[PC_W-1:0];
   end

   // global enable: instruction and service events win over a bus write
   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         ien_q <= 1'b0;
      end else if (take_hw || take_soft) begin
         ien_q <= 1'b0;
      end else if (ireturn_instr) begin
         ien_q <= 1'b1;
      end else if (disable_ints_instr) begin
         ien_q <= 1'b0;
      end else if (enable_ints_instr) begin
         ien_q <= 1'b1;
      end else if (wr_en && avs_address == REG_PSW) begin
         ien_q <= avs_writedata[PSW_IEN_BIT];
      end
   end

   // priority levels used for nesting; a trap leaves them alone
   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         current_priority_level_q <= RST_LEVEL;
         previous_priority_level_q <= RST_LEVEL;
      end else if (take_hw) begin
         previous_priority_level_q <= current_priority_level_q;
         current_priority_level_q <= arb.level;
      end else if (take_soft) begin
         previous_priority_level_q <= current_priority_level_q;
      end else if (ireturn_instr) begin
         current_priority_level_q <= previous_priority_level_q;
      end else if (wr_en && avs_address == REG_PSW) begin
         current_priority_level_q <= avs_writedata[PSW_CURRENT_PRIORITY_LEVEL_LSB +: PRIO_W];
         previous_priority_level_q <= avs_writedata[PSW_PREVIOUS_PRIORITY_LEVEL_LSB +: PRIO_W];
      end
   end

   // return address, overwritten by every nested hardware or soft entry, not by a trap
   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         interrupt_return_pc_q <= RST_PC;
      end else if (take_hw || take_soft) begin
         interrupt_return_pc_q <= core_pc;
      end else if (wr_en && avs_address == REG_RET_PC) begin
         interrupt_return_pc_q <= avs_writedata[PC_W-1:0];
      end
   end

   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) cstate_q <= RST_CSTATE;
      else if (wr_en && avs_address == REG_CSTATE) cstate_q <= avs_writedata[CSTATE_W-1:0];
   end

   // handler tracking for the lost-repeat case
   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         handler_q <= 1'b0;
         active_src_q <= 2'h0;
      end else if (take_hw) begin
         handler_q <= 1'b1;
         active_src_q <= arb.idx;
      end else if (ireturn_instr) begin
         handler_q <= 1'b0;
      end
   end

   // vector generation
   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         vector_take_q <= 1'b0;
         trap_take_q <= 1'b0;
         vector_addr_q <= RST_PC;
      end else begin
         vector_take_q <= take_trap | take_soft | take_hw;
         trap_take_q <= take_trap;
         if (take_trap) begin
            vector_addr_q <= vbase_q + VEC_TRAP;
         end else if (take_soft) begin
            vector_addr_q <= vbase_q + VEC_SOFT_BASE
                             + (PC_W'(soft_int_index) << VEC_SLOT_SHIFT);
         end else if (take_hw) begin
            vector_addr_q <= vbase_q + SRC_VEC[arb.idx];
         end
      end
   end

   // return: the cache loop takes precedence over the saved address
   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         return_take_q <= 1'b0;
         return_to_cache_q <= 1'b0;
         return_pc_q <= RST_PC;
      end else begin
         return_take_q <= ireturn_instr;
         if (ireturn_instr) begin
            return_to_cache_q <= cstate_q != RST_CSTATE;
            return_pc_q <= interrupt_return_pc_q;
         end
      end
   end

   assign vector_take = vector_take_q;
   assign trap_take = trap_take_q;
   assign vector_addr = vector_addr_q;
   assign return_take = return_take_q;
   assign return_to_cache = return_to_cache_q;
   assign return_pc = return_pc_q;
   assign global_int_enable = ien_q;
   assign current_priority_level = current_priority_level_q;
endmodule // dsp_int_ctrl
`default_nettype wire

// *** rtl/dsp_int_pkg.sv ***
// Purpose: constants shared by the core interrupt logic
// Assumes: 32-bit Avalon-MM register bus, byte addresses, one word per register
// Notes: vector offsets are in program words relative to the vector base
package dsp_int_pkg;
   localparam int NUM_SRC = 4;
   localparam int PRIO_W = 2;
   localparam int PC_W = 20;
   localparam int ADDR_W = 5;
   localparam int SOFT_W = 6;
   localparam int CSTATE_W = 16;

   // pending bit order follows vector address order
   localparam int SRC_TIMER = 0;
   localparam int SRC_EXT = 1;
   localparam int SRC_SERIAL = 2;
   localparam int SRC_IPC = 3;

   localparam logic [PC_W-1:0] VEC_TRAP = 20'h00008;
   localparam logic [PC_W-1:0] VEC_SOFT_BASE = 20'h00060;
   localparam logic [PC_W-1:0] VEC_SOFT_LAST = 20'h0015C;
   localparam int VEC_TABLE_WORDS = 352;
   localparam int VEC_SLOT_SHIFT = 2;
   localparam logic [PC_W-1:0] SRC_VEC [NUM_SRC] = '{20'h00010, 20'h00030, 20'h00038, 20'h00044};
   localparam int TRAP_PRIORITY = 5;
   localparam int EXT_HOLD_CYCLES = 2;
   localparam int EXT_MIN_LATENCY = 4;

   localparam logic [ADDR_W-1:0] REG_PENDING = 5'h00;
   localparam logic [ADDR_W-1:0] REG_PRIO_LO = 5'h04;
   localparam logic [ADDR_W-1:0] REG_PRIO_HI = 5'h08;
   localparam logic [ADDR_W-1:0] REG_VBASE = 5'h0C;
   localparam logic [ADDR_W-1:0] REG_PSW = 5'h10;
   localparam logic [ADDR_W-1:0] REG_RET_PC = 5'h14;
   localparam logic [ADDR_W-1:0] REG_CSTATE = 5'h18;

   localparam int PSW_IEN_BIT = 14;
   localparam int PSW_CURRENT_PRIORITY_LEVEL_LSB = 0;
   localparam int PSW_PREVIOUS_PRIORITY_LEVEL_LSB = 2;

   localparam logic [NUM_SRC-1:0] RST_PENDING = 4'h0;
   localparam logic [3:0] RST_PRIO_HALF = 4'h0;
   localparam logic [PC_W-1:0] RST_PC = 20'h00000;
   localparam logic [CSTATE_W-1:0] RST_CSTATE = 16'h0000;
   localparam logic [PRIO_W-1:0] RST_LEVEL = 2'h0;
endpackage

// *** rtl/ext_pin_sync.sv ***
// Purpose: catch rising edges of the external interrupt pin
// Assumes: pin held high at least two clocks
// Notes: first stage samples on the falling edge
`timescale 1ns/1ps
`default_nettype none
module ext_pin_sync (
   // clock and reset
   input wire logic clk,
   input wire logic resetn,
   // pin and edge
   input wire logic external_irq_pin,
   output logic rise
);
   logic s1_q;
   logic s2_q;
   logic s3_q;
   logic rise_q;

   always_ff @(negedge clk or negedge resetn) begin
      if (!resetn) s1_q <= 1'b0;
      else s1_q <= external_irq_pin;
   end

   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         s2_q <= 1'b0;
         s3_q <= 1'b0;
         rise_q <= 1'b0;
      end else begin
         s2_q <= s1_q;
         s3_q <= s2_q;
         // a level pin: only the low-to-high step counts as a request
         // registered so pin-to-vector never drops under four cycles
         rise_q <= s2_q & ~s3_q;
      end
   end

   assign rise = rise_q;
endmodule // ext_pin_sync
`default_nettype wire

// *** rtl/irq_arbiter.sv ***
// Purpose: pick the pending enabled source to service next
// Assumes: priority 0 means disabled
// Notes: purely combinational
`timescale 1ns/1ps
`default_nettype none
module irq_arbiter
   import dsp_int_pkg::*;
(
   arb_if.arbiter a
);
   always_comb begin
      logic [PRIO_W-1:0] p;
      p = '0;
      a.valid = 1'b0;
      a.idx = 2'h0;
      a.level = '0;
      // walk downward with >= so the lowest bit wins a tie
      for (int i = NUM_SRC - 1; i >= 0; i--) begin
         p = a.prio[i*PRIO_W +: PRIO_W];
         if (a.pending[i] && p != '0 && p > a.floor && (!a.valid || p >= a.level)) begin
            a.valid = 1'b1;
            a.idx = 2'(i);
            a.level = p;
         end
      end
   end
endmodule // irq_arbiter
`default_nettype wire
